// file: ccg_pkg.sv
package ccg_pkg;
   // register offsets, one byte per register
   localparam logic [7:0] A_CTRL0 = 8'h00;
   localparam logic [7:0] A_CTRL1 = 8'h01;
   localparam logic [7:0] A_CTRL3 = 8'h02;
   localparam logic [7:0] A_OSD = 8'h03;
   localparam logic [7:0] A_HS0 = 8'h04;
   localparam logic [7:0] A_COARSE = 8'h05;
   localparam logic [7:0] A_FINE = 8'h06;
   localparam logic [7:0] A_HSDIV = 8'h07;
   localparam logic [7:0] A_TRIM_AC = 8'h08;
   localparam logic [7:0] A_TRIM_AF = 8'h09;
   localparam logic [7:0] A_TRIM_BC = 8'h0a;
   localparam logic [7:0] A_TRIM_BF = 8'h0b;
   // system_clock_ctrl0 fields
   localparam int B_PSTOP = 2;
   localparam int B_SRUN = 3;
   localparam int B_SPIN = 4;
   localparam int B_MSTOP = 5;
   localparam int B_DIV8 = 6;
   localparam int B_SUBSEL = 7;
   // system_clock_ctrl1 fields
   localparam int B_SFB = 2;
   localparam int B_MPIN = 3;
   localparam int B_LSDIS = 4;
   localparam int B_DLO = 6;
   localparam int B_DHI = 7;
   // system_clock_ctrl3, osc_stop_detect_reg, hs_osc_ctrl0 fields
   localparam int B_OVR = 5;
   localparam int B_ODEN = 0;
   localparam int B_ODIRQ = 1;
   localparam int B_SRC = 2;
   localparam int B_FAIL = 3;
   localparam int B_HSEN = 0;
   localparam int B_OSEL = 1;
   localparam int B_D128 = 3;
   // reset values and writable masks
   localparam logic [7:0] RST_CTRL0 = 8'h60;
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [7:0] RST_CTRL3 = 8'h20;
   localparam logic [7:0] RST_OSD = 8'h04;
   localparam logic [7:0] RST_HS0 = 8'h00;
   localparam logic [7:0] M_CTRL0 = 8'hfc;
   localparam logic [7:0] M_CTRL1 = 8'hdc;
   localparam logic [7:0] M_CTRL3 = 8'h20;
   localparam logic [7:0] M_OSD = 8'h07;
   localparam logic [7:0] M_HS0 = 8'h0b;
   localparam logic [7:0] M_HSDIV = 8'h07;
   // timing
   localparam int CLK_NS = 40;
   localparam int MAIN_TIMEOUT_NS = 2000;
   localparam int MAIN_TIMEOUT_CYC = (MAIN_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
   localparam int SUB_STABLE_TICKS = 16;
   localparam logic [7:0] DIV128 = 8'h80;
   localparam logic [3:0] HS_DIV_BASE = 4'h2;
   localparam logic [4:0] PER_F2 = 5'h01;
   localparam logic [4:0] PER_F4 = 5'h03;
   localparam logic [4:0] PER_F8 = 5'h07;
   localparam logic [4:0] PER_F32 = 5'h1f;

   // cpu divide ratio from override, divide-by-eight and field
   function automatic logic [4:0] cpu_ratio(input logic ovr, input logic div8, input logic [1:0] fld);
      logic [4:0] r;
      r = 5'h01;
      if (ovr) begin
         r = 5'h01;
      end else if (div8) begin
         r = 5'h08;
      end else begin
         case (fld)
            2'b00: r = 5'h01;
            2'b01: r = 5'h02;
            2'b10: r = 5'h04;
            default: r = 5'h10;
         endcase
      end
      return r;
   endfunction : cpu_ratio
endpackage : ccg_pkg

// file: ccg_tick_div.sv
`timescale 1ns/1ns
// divides a stream of one-cycle ticks by a run-time ratio
module ccg_tick_div #(
   parameter int W = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic tick_in,
   input wire logic [W-1:0] ratio,
   output logic tick_out_ff
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic out;
   } ccg_div_st_t;
   ccg_div_st_t s_ff, nxt_s;

   assign tick_out_ff = s_ff.out;

   // ratio 0 or 1 passes every tick
   always_comb begin
      nxt_s = s_ff;
      nxt_s.out = 1'b0;
      if (tick_in) begin
         if (ratio <= W'(1) || s_ff.cnt >= ratio - W'(1)) begin
            nxt_s.cnt = '0;
            nxt_s.out = 1'b1;
         end else begin
            nxt_s.cnt = s_ff.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule : ccg_tick_div

// file: ccg_osc_watch.sv
`timescale 1ns/1ns
// counts an oscillator up to stable and flags a lost oscillation
module ccg_osc_watch #(
   parameter int STABLE_TICKS = 16,
   parameter int TIMEOUT = 50
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic run,
   input wire logic tick,
   output logic stable_ff,
   output logic fail_ff
);
   typedef struct packed {
      logic [15:0] ticks;
      logic [15:0] idle;
      logic stable;
      logic fail;
   } ccg_watch_st_t;
   ccg_watch_st_t s_ff, nxt_s;

   assign stable_ff = s_ff.stable;
   assign fail_ff = s_ff.fail;

   // fail is only judged once stable, so a slow start is no failure
   always_comb begin
      nxt_s = s_ff;
      if (!run) begin
         nxt_s = '0;
      end else if (tick) begin
         nxt_s.idle = '0;
         if (!s_ff.stable) begin
            nxt_s.ticks = s_ff.ticks + 16'h0001;
            nxt_s.stable = (s_ff.ticks >= 16'(STABLE_TICKS - 1));
         end
      end else if (s_ff.stable && !s_ff.fail) begin
         nxt_s.idle = s_ff.idle + 16'h0001;
         nxt_s.fail = (s_ff.idle >= 16'(TIMEOUT - 1));
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule : ccg_osc_watch

// file: ccg_clock_ctrl.sv
`timescale 1ns/1ns
module ccg_clock_ctrl import ccg_pkg::*; #(
   parameter logic [7:0] TRIM_A_COARSE = 8'h5a, // arbitrary value
   parameter logic [7:0] TRIM_A_FINE = 8'h3c, // arbitrary value
   parameter logic [7:0] TRIM_B_COARSE = 8'h4b, // arbitrary value
   parameter logic [7:0] TRIM_B_FINE = 8'h2d, // arbitrary value
   parameter int MAIN_TIMEOUT = MAIN_TIMEOUT_CYC,
   parameter int SUB_STABLE = SUB_STABLE_TICKS
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic main_osc_clock,
   input wire logic main_ext_clock,
   input wire logic sub_osc_clock,
   input wire logic ls_osc_tick,
   input wire logic hs_osc_tick,
   input wire logic wait_mode,
   input wire logic stop_mode,
   output logic main_osc_en,
   output logic sub_osc_en,
   output logic hs_osc_on,
   output logic ls_osc_on,
   output logic main_fb_on,
   output logic sub_fb_on,
   output logic [7:0] hs_osc_coarse_trim,
   output logic [7:0] hs_osc_fine_trim,
   output logic cpu_clk,
   output logic [4:0] periph_divided_clocks,
   output logic onchip_periph_clock,
   output logic hs_divided_clock,
   output logic hs_undivided_timer_clock,
   output logic ls_voltage_detect_clock,
   output logic div128_capture_clock
);
   typedef struct packed {
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [7:0] ctrl3;
      logic [7:0] osd;
      logic [7:0] hs0;
      logic [7:0] coarse;
      logic [7:0] fine;
      logic [2:0] hsdiv;
      logic [7:0] rdata;
      logic stop_d;
      logic [4:0] pcnt;
      logic cpu;
      logic [4:0] fclk;
      logic onchip;
      logic hsdivclk;
      logic hstimer;
      logic lsvd;
      logic d128;
      logic main_en;
      logic sub_en;
      logic hs_on;
      logic ls_on;
      logic main_fb;
      logic sub_fb;
   } ccg_st_t;

   localparam ccg_st_t RST_ST = '{ctrl0: RST_CTRL0, ctrl1: RST_CTRL1, ctrl3: RST_CTRL3,
      osd: RST_OSD, hs0: RST_HS0, default: '0};

   ccg_st_t s_ff, nxt_s;

   logic main_fail;
   logic sub_stable;
   logic cpu_tick;
   logic hs_div_tick;
   logic d128_tick;
   logic fallback;
   logic main_tick;
   logic ls_run;
   logic ls_tick;
   logic hs_run;
   logic hs_tick;
   logic sub_tick;
   logic onchip_tick;
   logic sys_tick;
   logic per_gate;
   logic [4:0] cpu_div;
   logic [3:0] hs_ratio;

   // merge a write into the writable bits only
   function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] m);
      return (old & ~m) | (wd & m);
   endfunction : wmerge

   // clock sources, all as one-cycle ticks on mclk
   always_comb begin
      fallback = main_fail && s_ff.osd[B_ODEN] && s_ff.osd[B_ODIRQ];
      // external clock on the output pin ignores the stop bit
      main_tick = main_osc_clock && (s_ff.main_en || main_ext_clock) && !stop_mode;
      ls_run = (!s_ff.ctrl1[B_LSDIS] || fallback) && !stop_mode;
      ls_tick = ls_osc_tick && ls_run;
      hs_run = s_ff.hs0[B_HSEN] && !stop_mode;
      hs_tick = hs_osc_tick && hs_run;
      sub_tick = sub_osc_clock && s_ff.sub_en && !stop_mode;
      onchip_tick = s_ff.hs0[B_OSEL] ? hs_div_tick : ls_tick;
      if (s_ff.ctrl0[B_SUBSEL] && sub_stable) begin
         sys_tick = sub_tick;
      end else if (s_ff.osd[B_SRC]) begin
         sys_tick = onchip_tick;
      end else begin
         sys_tick = main_tick;
      end
      // of the peripheral clocks only the f-clocks may halt in wait; the on-chip clocks keep running
      per_gate = !(wait_mode && s_ff.ctrl0[B_PSTOP]);
      // override keeps the cpu undivided until software clears it
      cpu_div = cpu_ratio(s_ff.ctrl3[B_OVR], s_ff.ctrl0[B_DIV8],
         {s_ff.ctrl1[B_DHI], s_ff.ctrl1[B_DLO]});
      hs_ratio = {1'b0, s_ff.hsdiv} + HS_DIV_BASE;
   end

   ccg_tick_div #(.W(5)) u_cpu_div (
      .mclk(mclk),
      .rst(rst),
      .tick_in(sys_tick),
      .ratio(cpu_div),
      .tick_out_ff(cpu_tick)
   );

   ccg_tick_div #(.W(4)) u_hs_div (
      .mclk(mclk),
      .rst(rst),
      .tick_in(hs_tick),
      .ratio(hs_ratio),
      .tick_out_ff(hs_div_tick)
   );

   // source chosen before dividing, so a switch costs one partial period
   ccg_tick_div #(.W(8)) u_d128_div (
      .mclk(mclk),
      .rst(rst),
      .tick_in(s_ff.hs0[B_D128] ? hs_div_tick : ls_tick),
      .ratio(DIV128),
      .tick_out_ff(d128_tick)
   );

   ccg_osc_watch #(.STABLE_TICKS(SUB_STABLE), .TIMEOUT(MAIN_TIMEOUT)) u_main_watch (
      .mclk(mclk),
      .rst(rst),
      .run(s_ff.main_en),
      .tick(main_tick),
      .stable_ff(),
      .fail_ff(main_fail)
   );

   ccg_osc_watch #(.STABLE_TICKS(SUB_STABLE), .TIMEOUT(MAIN_TIMEOUT)) u_sub_watch (
      .mclk(mclk),
      .rst(rst),
      .run(s_ff.sub_en),
      .tick(sub_tick),
      .stable_ff(sub_stable),
      .fail_ff()
   );

   // register file, hardware sets applied after writes so they win
   always_comb begin
      nxt_s = s_ff;
      nxt_s.rdata = 8'h00;
      if (reg_wr) begin
         case (reg_addr)
            A_CTRL0: nxt_s.ctrl0 = wmerge(s_ff.ctrl0, reg_wdata, M_CTRL0);
            A_CTRL1: nxt_s.ctrl1 = wmerge(s_ff.ctrl1, reg_wdata, M_CTRL1);
            A_CTRL3: nxt_s.ctrl3 = wmerge(s_ff.ctrl3, reg_wdata, M_CTRL3);
            A_OSD: nxt_s.osd = wmerge(s_ff.osd, reg_wdata, M_OSD);
            A_HS0: nxt_s.hs0 = wmerge(s_ff.hs0, reg_wdata, M_HS0);
            A_COARSE: nxt_s.coarse = reg_wdata;
            A_FINE: nxt_s.fine = reg_wdata;
            A_HSDIV: nxt_s.hsdiv = reg_wdata[2:0];
            default: ;
         endcase
      end
      if (stop_mode && !s_ff.stop_d) begin
         nxt_s.ctrl0[B_DIV8] = 1'b1;
      end
      if (fallback) begin
         nxt_s.osd[B_SRC] = 1'b1;
      end
      // stop entry is an edge, so div8 is forced once and software may clear it later
      nxt_s.stop_d = stop_mode;
      // read data only in the cycle after the strobe
      if (reg_rd) begin
         case (reg_addr)
            A_CTRL0: nxt_s.rdata = s_ff.ctrl0;
            A_CTRL1: nxt_s.rdata = s_ff.ctrl1;
            A_CTRL3: nxt_s.rdata = s_ff.ctrl3;
            A_OSD: nxt_s.rdata = {4'h0, main_fail, s_ff.osd[2:0]};
            A_HS0: nxt_s.rdata = s_ff.hs0;
            A_COARSE: nxt_s.rdata = s_ff.coarse;
            A_FINE: nxt_s.rdata = s_ff.fine;
            A_HSDIV: nxt_s.rdata = {5'h00, s_ff.hsdiv};
            A_TRIM_AC: nxt_s.rdata = TRIM_A_COARSE;
            A_TRIM_AF: nxt_s.rdata = TRIM_A_FINE;
            A_TRIM_BC: nxt_s.rdata = TRIM_B_COARSE;
            A_TRIM_BF: nxt_s.rdata = TRIM_B_FINE;
            default: nxt_s.rdata = 8'h00;
         endcase
      end
      // oscillator enables; stop mode overrides every bit
      nxt_s.main_en = s_ff.ctrl1[B_MPIN] && !s_ff.ctrl0[B_MSTOP] && !stop_mode;
      nxt_s.sub_en = s_ff.ctrl0[B_SPIN] && s_ff.ctrl0[B_SRUN] && !stop_mode;
      nxt_s.hs_on = hs_run;
      nxt_s.ls_on = ls_run;
      nxt_s.main_fb = s_ff.ctrl1[B_MPIN] && !stop_mode;
      nxt_s.sub_fb = s_ff.ctrl0[B_SPIN] && !s_ff.ctrl1[B_SFB] && !stop_mode;
      // peripheral prescaler counts system ticks
      if (sys_tick) begin
         nxt_s.pcnt = s_ff.pcnt + 5'h01;
      end
      nxt_s.fclk[0] = sys_tick && per_gate;
      nxt_s.fclk[1] = sys_tick && per_gate && ((s_ff.pcnt & PER_F2) == PER_F2);
      nxt_s.fclk[2] = sys_tick && per_gate && ((s_ff.pcnt & PER_F4) == PER_F4);
      nxt_s.fclk[3] = sys_tick && per_gate && ((s_ff.pcnt & PER_F8) == PER_F8);
      nxt_s.fclk[4] = sys_tick && per_gate && ((s_ff.pcnt & PER_F32) == PER_F32);
      // cpu clock stops in wait; the f-clocks also stop there with B_PSTOP set, the others keep running
      nxt_s.cpu = cpu_tick && !wait_mode && !stop_mode;
      nxt_s.onchip = onchip_tick;
      nxt_s.hsdivclk = hs_div_tick;
      nxt_s.hstimer = hs_tick;
      nxt_s.lsvd = ls_tick;
      nxt_s.d128 = d128_tick && !stop_mode;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_ff <= RST_ST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign reg_rdata = s_ff.rdata;
   assign main_osc_en = s_ff.main_en;
   assign sub_osc_en = s_ff.sub_en;
   assign hs_osc_on = s_ff.hs_on;
   assign ls_osc_on = s_ff.ls_on;
   assign main_fb_on = s_ff.main_fb;
   assign sub_fb_on = s_ff.sub_fb;
   assign hs_osc_coarse_trim = s_ff.coarse;
   assign hs_osc_fine_trim = s_ff.fine;
   assign cpu_clk = s_ff.cpu;
   assign periph_divided_clocks = s_ff.fclk;
   assign onchip_periph_clock = s_ff.onchip;
   assign hs_divided_clock = s_ff.hsdivclk;
   assign hs_undivided_timer_clock = s_ff.hstimer;
   assign ls_voltage_detect_clock = s_ff.lsvd;
   assign div128_capture_clock = s_ff.d128;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence main_start_s;
      reg_wr && reg_addr == A_CTRL0 && !reg_wdata[B_MSTOP] && s_ff.ctrl1[B_MPIN] && !stop_mode
         ##1 !stop_mode;
   endsequence

   main_off_a: assert property (!s_ff.ctrl1[B_MPIN] |=> !main_osc_en)
      else $error("main crystal enabled without pin function");
   main_start_a: assert property (main_start_s |=> main_osc_en)
      else $error("main crystal did not start");
   stop_halt_a: assert property (stop_mode [*3] |-> !cpu_clk && !main_osc_en && !main_fb_on && !sub_fb_on)
      else $error("clock or feedback active in stop mode");
   fallback_a: assert property (fallback && !stop_mode |=> s_ff.osd[B_SRC] && ls_osc_on)
      else $error("no low-speed fallback on crystal loss");
   hs_off_a: assert property (!s_ff.hs0[B_HSEN] |=> !hs_osc_on && !hs_undivided_timer_clock)
      else $error("high-speed oscillator on while disabled");
   sub_off_a: assert property (!s_ff.ctrl0[B_SRUN] |=> !sub_osc_en)
      else $error("sub oscillator on while not run");
   div8_force_a: assert property (stop_mode && !s_ff.stop_d |=> s_ff.ctrl0[B_DIV8])
      else $error("divide-by-eight not forced at stop entry");
   periph_wait_a: assert property (wait_mode && s_ff.ctrl0[B_PSTOP] |=> periph_divided_clocks == 5'h00)
      else $error("peripheral clock ran in wait");
   hs_timer_a: assert property (hs_osc_tick && s_ff.hs0[B_HSEN] && !stop_mode |=> hs_undivided_timer_clock)
      else $error("timer clock missed a high-speed tick");
   ls_vd_a: assert property (s_ff.ctrl1[B_LSDIS] && !fallback |=> !ls_voltage_detect_clock)
      else $error("detect clock ran while disabled");
   // each source tick must reach its output one cycle later
   ls_vd_on_a: assert property (ls_osc_tick && !s_ff.ctrl1[B_LSDIS] && !stop_mode |=> ls_voltage_detect_clock)
      else $error("detect clock missed a low-speed tick");
   hs_on_a: assert property (s_ff.hs0[B_HSEN] && !stop_mode |=> hs_osc_on)
      else $error("high-speed oscillator not started");
   hs_div_off_a: assert property (!s_ff.hs0[B_HSEN] |=> ##1 !hs_divided_clock)
      else $error("divided high-speed clock ran while disabled");
   fclk_nest_a: assert property (periph_divided_clocks[4:1] != 4'h0 |-> periph_divided_clocks[0])
      else $error("slow peripheral clock without system tick");
   fb_stop_a: assert property (stop_mode |=> !main_fb_on && !sub_fb_on)
      else $error("feedback resistor kept in stop mode");
   onchip_hs_a: assert property (s_ff.hs0[B_OSEL] |=> onchip_periph_clock == $past(hs_div_tick))
      else $error("on-chip clock not the divided high-speed clock");
   onchip_ls_a: assert property (!s_ff.hs0[B_OSEL] |=> onchip_periph_clock == $past(ls_tick))
      else $error("on-chip clock not the low-speed clock");

   // sub start differs from the main start (pin bit preset in ctrl1): pin function and run bit in one write
   sequence sub_start_s;
      reg_wr && reg_addr == A_CTRL0 && reg_wdata[B_SPIN] && reg_wdata[B_SRUN] && !stop_mode
         ##1 !stop_mode;
   endsequence

   // a main tick with the crystal selected reaches f1 next cycle
   sequence main_src_s;
      main_tick && !s_ff.osd[B_SRC] && !(s_ff.ctrl0[B_SUBSEL] && sub_stable) && per_gate;
   endsequence

   sub_start_a: assert property (sub_start_s |=> sub_osc_en)
      else $error("sub oscillator did not start");
   main_src_a: assert property (main_src_s |=> periph_divided_clocks[0])
      else $error("main crystal tick lost as system clock");
endmodule : ccg_clock_ctrl

// file: ccg_osc_model.sv
`timescale 1ns/1ns
// oscillator stand-in: one-cycle ticks only while enabled
module ccg_osc_model #(
   parameter int PERIOD = 4
) (
   input wire logic mclk,
   input wire logic en,
   input wire logic kill,
   output logic tick
);
   int cnt = 0;
   // kill models a crystal that dies while still enabled
   always @(posedge mclk) begin
      cnt <= (cnt + 1) % PERIOD;
      tick <= en && !kill && cnt == 0;
   end
endmodule : ccg_osc_model

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top import ccg_pkg::*;;
   localparam logic [7:0] TAC = 8'h91; // arbitrary value
   localparam logic [7:0] TAF = 8'h62; // arbitrary value
   localparam logic [7:0] TBC = 8'ha7; // arbitrary value
   localparam logic [7:0] TBF = 8'h1e; // arbitrary value
   logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, clr = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   logic main_ext_clock = 1'b0, wait_mode = 1'b0, stop_mode = 1'b0, main_kill = 1'b0, osc_kill = 1'b0;
   logic [7:0] reg_rdata, coarse, fine;
   logic main_tick, sub_tick, ls_tick, hs_tick, cpu_clk, main_osc_en, sub_osc_en;
   logic hs_osc_on, ls_osc_on, main_fb_on, sub_fb_on, onchip, hsdiv, hsund, lsvd, d128;
   logic [4:0] fclk;
   logic [14:0] p;
   int cnt [15];
   int failures = 0, cmp_count = 0;

   always #20 mclk = ~mclk;

   // far side: the external clock keeps the main tick alive
   ccg_osc_model #(.PERIOD(3)) main_m (.mclk(mclk), .en(main_osc_en | main_ext_clock), .kill(main_kill),
      .tick(main_tick));
   // on-chip and sub stand-ins share one kill so a dead source can be shown
   ccg_osc_model #(.PERIOD(5)) sub_m (.mclk(mclk), .en(sub_osc_en), .kill(osc_kill), .tick(sub_tick));
   ccg_osc_model ls_m (.mclk(mclk), .en(ls_osc_on), .kill(osc_kill), .tick(ls_tick));
   ccg_osc_model #(.PERIOD(1)) hs_m (.mclk(mclk), .en(hs_osc_on), .kill(osc_kill), .tick(hs_tick));

   // short counts keep fail and stable detection quick
   ccg_clock_ctrl #(.TRIM_A_COARSE(TAC), .TRIM_A_FINE(TAF), .TRIM_B_COARSE(TBC), .TRIM_B_FINE(TBF),
      .MAIN_TIMEOUT(4), .SUB_STABLE(4)) uut (
      .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_osc_clock(main_tick),
      .main_ext_clock(main_ext_clock), .sub_osc_clock(sub_tick), .ls_osc_tick(ls_tick),
      .hs_osc_tick(hs_tick), .wait_mode(wait_mode), .stop_mode(stop_mode),
      .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en), .hs_osc_on(hs_osc_on),
      .ls_osc_on(ls_osc_on), .main_fb_on(main_fb_on), .sub_fb_on(sub_fb_on),
      .hs_osc_coarse_trim(coarse), .hs_osc_fine_trim(fine), .cpu_clk(cpu_clk),
      .periph_divided_clocks(fclk), .onchip_periph_clock(onchip), .hs_divided_clock(hsdiv),
      .hs_undivided_timer_clock(hsund), .ls_voltage_detect_clock(lsvd),
      .div128_capture_clock(d128));

   // pulse counters: 0 ls, 1 hs, 2 main, 3 sub, 4 cpu, 5-9 f1-f32, 10 onchip
   assign p = {d128, lsvd, hsund, hsdiv, onchip, fclk, cpu_clk, sub_tick, main_tick, hs_tick, ls_tick};
   always @(posedge mclk) begin
      foreach (cnt[i]) cnt[i] <= clr ? 0 : cnt[i] + int'(p[i] === 1'b1);
   end

   task automatic finish_test;
      $display("failures %0d comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   task automatic ck(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("FAIL t=%0t got %h exp %h", $time, g, e);
      end
   endtask : ck

   // divider phase leaves one pulse of slack either way
   task automatic near(input int i, input int e);
      cmp_count++;
      if (cnt[i] < e - 1 || cnt[i] > e + 1) begin
         failures++;
         $display("FAIL t=%0t counter %0d got %h exp %h", $time, i, cnt[i], e);
      end
   endtask : near

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd_ck(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 ck(reg_rdata, e);
   endtask : rd_ck

   task automatic settle2;
      repeat (2) @(posedge mclk);
      #1;
   endtask : settle2

   // settle first so pulses already in the pipeline are not counted
   task automatic measure(input int n);
      repeat (8) @(posedge mclk);
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
      repeat (n) @(posedge mclk);
      #1;
   endtask : measure

   task automatic do_reset;
      @(posedge mclk);
      rst <= 1'b1;
      {main_ext_clock, wait_mode, stop_mode, main_kill, osc_kill} <= 5'h00;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
   endtask : do_reset

   task automatic t_reset;
      logic [7:0] rv [13];
      rv = '{RST_CTRL0, RST_CTRL1, RST_CTRL3, RST_OSD, RST_HS0, 8'h00, 8'h00, 8'h00, TAC, TAF, TBC, TBF, 8'h00};
      do_reset();
      wr(A_TRIM_AC, 8'h00);
      wr(8'h0c, 8'hff);
      for (int i = 0; i < 13; i++) rd_ck(8'(i), rv[i]);
      ck({main_osc_en, sub_osc_en, hs_osc_on}, 3'h0);
      measure(400);
      near(0, 100);
      near(4, cnt[0]);
      near(13, cnt[0]);
      near(12, 0);
      // a dead low-speed source must starve the cpu and detect clocks
      @(posedge mclk);
      osc_kill <= 1'b1;
      measure(200);
      near(4, 0);
      near(13, 0);
      @(posedge mclk);
      osc_kill <= 1'b0;
      wr(A_CTRL1, 8'h10);
      measure(200);
      ck(ls_osc_on, 1'b0);
      near(13, 0);
   endtask : t_reset

   task automatic t_cpu;
      int rt [4] = '{1, 2, 4, 16};
      do_reset();
      wr(A_CTRL3, 8'h00);
      for (int f = 0; f < 4; f++) begin
         wr(A_CTRL1, 8'(f << 6));
         wr(A_CTRL0, 8'h20);
         measure(640);
         near(4, cnt[0] / rt[f]);
      end
      wr(A_CTRL0, 8'h60);
      measure(640);
      near(4, cnt[0] / 8);
      for (int k = 0; k < 5; k++) near(5 + k, cnt[0] / (k == 4 ? 32 : 1 << k));
      @(posedge mclk);
      wait_mode <= 1'b1;
      measure(640);
      near(4, 0);
      near(5, cnt[0]);
      wr(A_CTRL0, 8'h64);
      measure(640);
      for (int k = 0; k < 5; k++) near(5 + k, 0);
      near(10, cnt[0]);
      near(13, cnt[0]);
   endtask : t_cpu

   task automatic t_hs;
      do_reset();
      @(posedge mclk);
      wait_mode <= 1'b1;
      wr(A_HS0, 8'h01);
      settle2();
      ck(hs_osc_on, 1'b1);
      for (int c = 0; c < 8; c++) begin
         wr(A_HSDIV, 8'(c));
         measure(480);
         near(1, 480);
         near(12, cnt[1]);
         near(11, cnt[1] / (c + 2));
      end
      wr(A_HSDIV, 8'h00);
      wr(A_HS0, 8'h0b);
      measure(1100);
      near(10, cnt[11]);
      near(14, cnt[11] / 128);
      wr(A_HS0, 8'h01);
      measure(2100);
      near(10, cnt[0]);
      near(14, cnt[13] / 128);
   endtask : t_hs

   task automatic t_main;
      do_reset();
      wr(A_CTRL1, 8'h08);
      wr(A_CTRL0, 8'h40);
      settle2();
      ck(main_osc_en, 1'b1);
      wr(A_OSD, 8'h00);
      measure(400);
      near(2, 133);
      near(4, cnt[2]);
      wr(A_CTRL1, 8'h18);
      // one detect bit alone must not fall back
      wr(A_OSD, 8'h01);
      @(posedge mclk);
      main_kill <= 1'b1;
      measure(60);
      rd_ck(A_OSD, 8'h09);
      ck(ls_osc_on, 1'b0);
      wr(A_OSD, 8'h03);
      measure(60);
      rd_ck(A_OSD, 8'h0f);
      ck(ls_osc_on, 1'b1);
      measure(400);
      near(4, 100);
      // external clock with the stop bit still set
      do_reset();
      wr(A_CTRL1, 8'h08);
      wr(A_OSD, 8'h00);
      @(posedge mclk);
      main_ext_clock <= 1'b1;
      measure(400);
      near(4, 133);
   endtask : t_main

   task automatic t_sub;
      do_reset();
      wr(A_CTRL0, 8'h70);
      wr(A_CTRL0, 8'h78);
      settle2();
      ck(sub_osc_en, 1'b1);
      measure(60);
      wr(A_CTRL0, 8'hf8);
      measure(400);
      near(4, 80);
   endtask : t_sub

   task automatic t_stop;
      do_reset();
      wr(A_CTRL1, 8'h08);
      wr(A_CTRL3, 8'h00);
      wr(A_CTRL0, 8'h18);
      measure(60);
      ck({main_fb_on, sub_fb_on}, 2'h3);
      wr(A_CTRL1, 8'h0c);
      settle2();
      ck(sub_fb_on, 1'b0);
      @(posedge mclk);
      stop_mode <= 1'b1;
      measure(200);
      ck({main_osc_en, sub_osc_en, main_fb_on, sub_fb_on}, 4'h0);
      near(4, 0);
      near(5, 0);
      near(13, 0);
      rd_ck(A_CTRL0, 8'h58);
   endtask : t_stop

   task automatic t_trim;
      do_reset();
      wr(A_COARSE, TAC);
      wr(A_FINE, TAF);
      settle2();
      ck({coarse, fine}, {TAC, TAF});
      wr(A_COARSE, TBC);
      wr(A_FINE, TBF);
      settle2();
      ck({coarse, fine}, {TBC, TBF});
   endtask : t_trim

   // main sequence
   initial begin
      t_reset();
      t_cpu();
      t_hs();
      t_main();
      t_sub();
      t_stop();
      t_trim();
      finish_test();
   end

   // watchdog well beyond the expected fifteen thousand cycles
   initial begin
      repeat (60000) @(posedge mclk);
      failures++;
      finish_test();
   end
endmodule : tb_top
